// ==== inc/bmu_regs.svh ====
// Purpose: constants of the decorated-store and/or read-modify-write engine
// Assumes: 32-bit addresses and data on both bus ports
// Notes: no software registers; only address decoding, bus encoding and reset value constants
// Function
// - slave wait states stall the upstream master cycle for cycle
// - decorated and store reads, ands with write data, writes back indivisibly
// - decorated or store reads, ors with write data, writes back indivisibly
// - read and write-back use the originating store's byte, halfword or word size
// - address bits 30:29 pick region, 01 sram and 10 peripheral
// - address bits 28:26 equal to 001 select the and operation
// - address bits 28:26 equal to 010 select the or operation
// - low twenty address bits are the offset into the selected region
// - downstream address is decorated address masked with e00fffff for read and write
// - first cycle forwards address, decodes, turns write into read, captures attributes
// - second cycle presents captured address and attributes again as a write
// - second cycle combines slave read data with write data into a result register
// - third cycle drives the result register onto downstream write data
// - don't-care address bits affect neither operation nor target address
// - upstream transfer stays stalled while modified data is formed
// - undecorated accesses pass combinationally to the slave side unchanged
`ifndef BMU_REGS_SVH
`define BMU_REGS_SVH

// ****************************************
// address decoration
// ****************************************
`define BMU_ADDR_MASK 32'hE00F_FFFF
`define BMU_TOP_BIT 31
`define BMU_REGION_HI 30
`define BMU_REGION_LO 29
`define BMU_OP_HI 28
`define BMU_OP_LO 26
`define BMU_REGION_SRAM 2'h1
`define BMU_REGION_PERIPH 2'h2
`define BMU_OP_AND 3'h1
`define BMU_OP_OR 3'h2

// ****************************************
// bus encodings and reset values
// ****************************************
`define BMU_TRANS_IDLE 2'h0
`define BMU_TRANS_NONSEQ 2'h2
`define BMU_RST_ADDR 32'h0000_0000
`define BMU_RST_DATA 32'h0000_0000
`define BMU_RST_SIZE 3'h0
`define BMU_RST_PROT 4'h0

`endif

// ==== inc/bmu_pkg.sv ====
// Purpose: types of the decorated-store engine
// Assumes: nothing beyond the constants header
// Notes: states of the read-modify-write sequencer
package bmu_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    BMU_ST_PASS = 2'b00,
    BMU_ST_READ = 2'b01,
    BMU_ST_WRITE = 2'b10
  } bmu_state_e;

  typedef enum logic {
    BMU_FN_AND = 1'b0,
    BMU_FN_OR = 1'b1
  } bmu_fn_e;

endpackage

// ==== core/bmu_engine.sv ====
// Purpose: bit_manipulation_unit decorated and/or store engine between master and slave bus
// Assumes: two-stage pipelined bus, single clock domain, synchronous reset
// Notes: other decorations and all loads pass through as plain accesses
`timescale 1ns/1ps
`include "bmu_regs.svh"

module bmu_engine
  import bmu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // upstream master port
  input wire logic [31:0] m_haddr_i,
  input wire logic [1:0] m_htrans_i,
  input wire logic m_hwrite_i,
  input wire logic [2:0] m_hsize_i,
  input wire logic [3:0] m_hprot_i,
  input wire logic [31:0] m_hwdata_i,
  output logic [31:0] m_hrdata_o,
  output logic m_hready_o,
  output logic m_hresp_o,
  // downstream slave port
  output logic [31:0] s_haddr_o,
  output logic [1:0] s_htrans_o,
  output logic s_hwrite_o,
  output logic [2:0] s_hsize_o,
  output logic [3:0] s_hprot_o,
  output logic [31:0] s_hwdata_o,
  input wire logic [31:0] s_hrdata_i,
  input wire logic s_hready_i,
  input wire logic s_hresp_i
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_decorated(input logic [31:0] addr, input logic [1:0] trans, input logic wr);
    logic [1:0] region;
    logic [2:0] op;
    region = addr[`BMU_REGION_HI:`BMU_REGION_LO];
    op = addr[`BMU_OP_HI:`BMU_OP_LO];
    is_decorated = trans[1] && wr && !addr[`BMU_TOP_BIT] &&
                   ((region == `BMU_REGION_SRAM) || (region == `BMU_REGION_PERIPH)) &&
                   ((op == `BMU_OP_AND) || (op == `BMU_OP_OR));
  endfunction

  function automatic logic [31:0] strip_addr(input logic [31:0] addr);
    // decoration bits and don't-care bits are cleared alike
    strip_addr = addr & `BMU_ADDR_MASK;
  endfunction

  // ****************************************
  // state
  // ****************************************
  bmu_state_e state;
  bmu_state_e next_state;
  logic [31:0] cap_addr;
  logic [31:0] next_cap_addr;
  logic [2:0] cap_size;
  logic [2:0] next_cap_size;
  logic [3:0] cap_prot;
  logic [3:0] next_cap_prot;
  bmu_fn_e cap_fn;
  bmu_fn_e next_cap_fn;
  logic [31:0] result;
  logic [31:0] next_result;
  logic take_decorated;

  // a new decorated store is accepted only when the upstream address phase completes
  assign take_decorated = m_hready_o && is_decorated(m_haddr_i, m_htrans_i, m_hwrite_i);

  // ****************************************
  // sequencer next values
  // ****************************************
  always_comb begin
    next_state = state;
    next_cap_addr = cap_addr;
    next_cap_size = cap_size;
    next_cap_prot = cap_prot;
    next_cap_fn = cap_fn;
    next_result = result;
    case (state)
      BMU_ST_READ: begin
        if (s_hready_i) begin
          // lane replication by the master lets the full word be combined
          if (cap_fn == BMU_FN_AND) begin
            next_result = s_hrdata_i & m_hwdata_i;
          end else begin
            next_result = s_hrdata_i | m_hwdata_i;
          end
          next_state = BMU_ST_WRITE;
        end
      end
      default: begin
        if (state == BMU_ST_WRITE && s_hready_i) begin
          next_state = BMU_ST_PASS;
        end
        if (take_decorated) begin
          next_cap_addr = strip_addr(m_haddr_i);
          next_cap_size = m_hsize_i;
          next_cap_prot = m_hprot_i;
          if (m_haddr_i[`BMU_OP_HI:`BMU_OP_LO] == `BMU_OP_AND) begin
            next_cap_fn = BMU_FN_AND;
          end else begin
            next_cap_fn = BMU_FN_OR;
          end
          next_state = BMU_ST_READ;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= BMU_ST_PASS;
      cap_addr <= `BMU_RST_ADDR;
      cap_size <= `BMU_RST_SIZE;
      cap_prot <= `BMU_RST_PROT;
      cap_fn <= BMU_FN_AND;
      result <= `BMU_RST_DATA;
    end else begin
      state <= next_state;
      cap_addr <= next_cap_addr;
      cap_size <= next_cap_size;
      cap_prot <= next_cap_prot;
      cap_fn <= next_cap_fn;
      result <= next_result;
    end
  end

  // ****************************************
  // bus steering
  // ****************************************
  // the pass path is combinational so plain accesses see no added latency
  always_comb begin
    s_haddr_o = m_haddr_i;
    s_htrans_o = m_htrans_i;
    s_hwrite_o = m_hwrite_i;
    s_hsize_o = m_hsize_i;
    s_hprot_o = m_hprot_i;
    s_hwdata_o = m_hwdata_i;
    m_hrdata_o = s_hrdata_i;
    m_hready_o = s_hready_i;
    m_hresp_o = s_hresp_i;
    case (state)
      BMU_ST_READ: begin
        // write address phase recirculated; master held in its data phase
        s_haddr_o = cap_addr;
        s_htrans_o = `BMU_TRANS_NONSEQ;
        s_hwrite_o = 1'b1;
        s_hsize_o = cap_size;
        s_hprot_o = cap_prot;
        m_hready_o = 1'b0;
      end
      BMU_ST_WRITE: begin
        s_hwdata_o = result;
      end
      default: begin
      end
    endcase
    if (state != BMU_ST_READ && is_decorated(m_haddr_i, m_htrans_i, m_hwrite_i)) begin
      // decorated write becomes a read of the real location
      s_haddr_o = strip_addr(m_haddr_i);
      s_hwrite_o = 1'b0;
    end
  end

endmodule // bmu_engine

// ==== tb/bmu_engine_sva.sv ====
// Purpose: port checks of bmu_engine
// Assumes: one clock, sync reset
// Notes: rd marks the stalled read cycle
`timescale 1ns/1ps
module bmu_engine_sva(
  input wire logic clk_sys_i, sys_rst_i, m_hwrite_i, m_hready_o, s_hwrite_o, s_hready_i, m_hresp_o, s_hresp_i,
  input wire logic [1:0] m_htrans_i, s_htrans_o,
  input wire logic [2:0] m_hsize_i, s_hsize_o,
  input wire logic [3:0] m_hprot_i, s_hprot_o,
  input wire logic [31:0] m_haddr_i, m_hwdata_i, s_haddr_o, s_hwdata_o, s_hrdata_i);
  logic decreq, dec, rd, orop;
  // a decorated request is converted even while a previous transfer stalls it
  assign decreq = m_htrans_i[1] && m_hwrite_i && !m_haddr_i[31] && ^m_haddr_i[30:29]
    && m_haddr_i[28:26] inside {3'h1, 3'h2};
  assign dec = m_hready_o && decreq;
  always_ff @(posedge clk_sys_i) begin
    rd <= !sys_rst_i && (dec || (rd && !s_hready_i));
    orop <= dec ? m_haddr_i[27] : orop;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_wait_pass: assert property (!rd |-> m_hready_o == s_hready_i) else $error("stall");
  a_read_stall: assert property (rd |-> !m_hready_o) else $error("no stall");
  a_read_conv: assert property (dec |-> !s_hwrite_o && s_haddr_o == (m_haddr_i & 32'hE00F_FFFF))
    else $error("read addr");
  a_write_recirc: assert property (dec |=> s_hwrite_o && s_htrans_o == 2'h2 && s_hsize_o == $past(m_hsize_i)
    && s_haddr_o == ($past(m_haddr_i) & 32'hE00F_FFFF)) else $error("write addr");
  a_attr_keep: assert property (dec |=> s_hprot_o == $past(m_hprot_i)) else $error("attr");
  a_and_result: assert property (rd && s_hready_i && !orop |=>
    s_hwdata_o == ($past(s_hrdata_i) & $past(m_hwdata_i))) else $error("and data");
  a_or_result: assert property (rd && s_hready_i && orop |=>
    s_hwdata_o == ($past(s_hrdata_i) | $past(m_hwdata_i))) else $error("or data");
  a_pass_thru: assert property (!rd && !decreq |-> s_haddr_o == m_haddr_i && s_hwrite_o == m_hwrite_i
    && s_htrans_o == m_htrans_i) else $error("pass");
  a_resp_pass: assert property (m_hresp_o == s_hresp_i) else $error("resp");
endmodule // bmu_engine_sva
bind bmu_engine bmu_engine_sva bmu_engine_sva_inst(.*);

// ==== tb/bmu_slave_model.sv ====
// Purpose: memory slave behind the engine
// Assumes: 16 words, lanes by size
// Notes: read data inverted except in the ready cycle of a read phase
`timescale 1ns/1ps
module bmu_slave_model(
  input wire logic clk_sys_i, s_hwrite_o,
  input wire logic [1:0] s_htrans_o, waits,
  input wire logic [2:0] s_hsize_o,
  input wire logic [31:0] s_haddr_o, s_hwdata_o,
  output logic [31:0] s_hrdata_i,
  output logic s_hready_i, s_hresp_i);
  logic [31:0] mem [16];
  logic [31:0] a;
  logic [2:0] sz;
  logic act = 1'b0;
  logic wr;
  logic [1:0] cnt = 2'h0;
  assign s_hready_i = cnt == 2'h0;
  assign s_hresp_i = 1'b0;
  assign s_hrdata_i = act && !wr && s_hready_i ? mem[a[5:2]] : ~mem[a[5:2]];
  always @(posedge clk_sys_i) begin
    if (!s_hready_i) cnt <= cnt - 2'h1;
    else begin
      if (act && wr) for (int i = 0; i < 4; i++)
        if (sz == 2 || (sz == 1 && i[1] == a[1]) || i == a[1:0]) mem[a[5:2]][8*i+:8] <= s_hwdata_o[8*i+:8];
      act <= s_htrans_o[1]; a <= s_haddr_o; wr <= s_hwrite_o; sz <= s_hsize_o;
      cnt <= s_htrans_o[1] ? waits : 2'h0;
    end
  end
endmodule // bmu_slave_model

// ==== tb/decorated_store_and_or_rmw_test.sv ====
// Purpose: self-checking bench of bmu_engine
// Assumes: master waits for hready, no pipelining
// Notes: slave waits vary per store
`timescale 1ns/1ps
module decorated_store_and_or_rmw_test;
  logic clk_sys_i, sys_rst_i, m_hwrite_i, m_hready_o, m_hresp_o, s_hwrite_o, s_hready_i, s_hresp_i;
  logic [1:0] m_htrans_i, s_htrans_o, waits;
  logic [2:0] m_hsize_i, s_hsize_o;
  logic [3:0] m_hprot_i, s_hprot_o;
  logic [31:0] m_haddr_i, m_hwdata_i, m_hrdata_o, s_haddr_o, s_hwdata_o, s_hrdata_i, rd;
  int failures, checks;
  bmu_engine bmu_engine_inst(.*);
  bmu_slave_model bmu_slave_model_inst(.*);
  initial begin clk_sys_i = 0; forever #5 clk_sys_i = ~clk_sys_i; end
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin failures++; $display("wrong value %0t: %h not %h", $time, got, exp); end
  endtask
  task automatic complete_run;
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ready and read data are looked at mid-cycle, where they stand for the coming edge
  task automatic bus(input logic [31:0] ad, wd, input logic wr, input logic [2:0] sz);
    int n;
    logic ok;
    m_haddr_i <= ad; m_hwrite_i <= wr; m_hsize_i <= sz; m_htrans_i <= 2'h2; m_hprot_i <= {1'b1, sz};
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(negedge clk_sys_i);
        ok = m_hready_o;
        rd = m_hrdata_o;
        @(posedge clk_sys_i);
        n++;
      end while (!ok && n < 40);
      if (!ok) begin failures++; complete_run(); end
      if (p == 0) begin m_htrans_i <= 2'h0; m_hwdata_i <= wd; end
    end
  endtask
  // xor decoration and loads stay plain
  task automatic plain_pass;
    bus(32'h2C00_0024, 32'hCAFE_0001, 1, 2);
    bus(32'h2000_0024, 0, 0, 2);
    chk(rd, 32'hCAFE_0001);
  endtask
  task automatic rmw(input logic orop, input logic [2:0] sz);
    logic [31:0] base, rep, m, old, exp;
    base = sz[0] ? 32'h4000_0010 : 32'h2000_0010;
    rep = sz == 0 ? {4{8'hF0}} : sz == 1 ? {2{16'hC3F0}} : 32'h0F3C_C3F0;
    m = sz == 0 ? 32'h0000_FF00 : sz == 1 ? 32'hFFFF_0000 : 32'hFFFF_FFFF;
    old = 32'hA5A5_5A5A;
    exp = (old & ~m) | ((orop ? old | rep : old & rep) & m);
    waits <= 2'h0;
    bus(base, old, 1, 2);
    waits <= sz[1:0];
    // don't-care bits 25:20 set, aligned offsets
    bus(base | 32'h03F0_0000 | (orop ? 32'h0800_0000 : 32'h0400_0000) | (sz == 0 ? 1 : sz == 1 ? 2 : 0),
      rep, 1, sz);
    waits <= 2'h0;
    bus(base, 0, 0, 2);
    chk(rd, exp);
  endtask
  initial begin
    sys_rst_i = 1; m_haddr_i = 0; m_htrans_i = 0; m_hwrite_i = 0; m_hsize_i = 0;
    m_hprot_i = 0; m_hwdata_i = 0; waits = 0; failures = 0; checks = 0;
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 0;
    plain_pass();
    for (int o = 0; o < 2; o++) for (int s = 0; s < 3; s++) rmw(o[0], s[2:0]);
    complete_run();
  end
endmodule // decorated_store_and_or_rmw_test
